// ---- hw/scp_top.sv ----
// Functional notes
// - Snoop writes to keyboard ports 60h, 64h
// - D1h then 02h raises address gate
// - FEh to 64h pulses warm reset
// - Config 21h bit5 low waits for halt
// - After D0h, 60h reads gate and reset
// - Decode cycle-definition signals for special cycles
// - Config 20h[7:6] fixed read-only revision
// - Sample three straps at reset release
// - Tristate strap combination floats all pins
// - Straps 000 and 010 drive checker patterns, 001 floats, others normal
// - Thirteen configuration registers, indirect access
// - Index at 22h, data at 24h
// - Index invalidated after each data access
// - Reserved configuration bits reset and stay zero
// - Bit7 parity flag, cleared by bit2
// - Bit6 channel check flag, cleared by bit3
// - Bit5 reads live timer output
// - Bit4 toggles every refresh cycle
// - Channel check raises NMI unless bit3
// - Parity error raises NMI unless bit2
// - Bit1 gates timer onto speaker
// - Bit0 drives timer channel 2 gate
`timescale 1ns/100ps
module scp_top
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [15:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic io_wr,
   input wire logic io_rd,
   output logic [7:0] io_rdata,
   output logic io_rdata_valid,
   input wire logic cyc_strobe,
   input wire logic mem_or_io_select,
   input wire logic data_or_control_select,
   input wire logic cyc_write,
   input wire logic cyc_halt_sel,
   input wire logic [2:0] strap_in,
   input wire logic timer_ch2_output,
   input wire logic refresh_pulse,
   input wire logic parity_error,
   input wire logic channel_check_in_n,
   output logic addr20_gate_pin,
   output logic addr20_gate_pin_oe,
   output logic processor_warm_reset,
   output logic processor_warm_reset_oe,
   output logic speaker_out,
   output logic speaker_out_oe,
   output logic timer_ch2_gate,
   output logic timer_ch2_gate_oe,
   output logic nmi,
   output logic nmi_oe
);
   localparam int WR_CNT_W = $clog2(scp_pkg::WARM_RESET_CYCLES + 1);

   logic wr_kbd_data;
   logic wr_kbd_cmd;
   logic wr_sys_b;
   logic wr_index;
   logic wr_data;
   logic rd_kbd_data;
   logic rd_data;
   logic special_cyc;
   logic halt_cyc;
   logic shutdown_cyc;
   logic reset_request;

   assign wr_kbd_data = io_wr && (io_addr == scp_pkg::PORT_KBD_DATA);
   assign wr_kbd_cmd = io_wr && (io_addr == scp_pkg::PORT_KBD_CMD);
   assign wr_sys_b = io_wr && (io_addr == scp_pkg::PORT_SYS_B);
   assign wr_index = io_wr && (io_addr == scp_pkg::PORT_CFG_INDEX);
   assign wr_data = io_wr && (io_addr == scp_pkg::PORT_CFG_DATA);
   assign rd_kbd_data = io_rd && (io_addr == scp_pkg::PORT_KBD_DATA);
   assign rd_data = io_rd && (io_addr == scp_pkg::PORT_CFG_DATA);

   // Special cycle: I/O space, control, write
   assign special_cyc = cyc_strobe && !mem_or_io_select && !data_or_control_select
      && cyc_write;
   assign halt_cyc = special_cyc && cyc_halt_sel;
   assign shutdown_cyc = special_cyc && !cyc_halt_sel;

   // Strap capture at reset release
   logic rstn_d_r;
   scp_pkg::scp_test_type test_mode_r;
   scp_pkg::scp_test_type test_mode_nxt;

   always_comb
   begin
      case (strap_in)
         3'b001: test_mode_nxt = scp_pkg::TM_TRISTATE;
         3'b000: test_mode_nxt = scp_pkg::TM_ODD_HIGH;
         3'b010: test_mode_nxt = scp_pkg::TM_EVEN_HIGH;
         default: test_mode_nxt = scp_pkg::TM_NORMAL;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         rstn_d_r <= 1'b0;
      end
      else
      begin
         rstn_d_r <= 1'b1;
      end
   end

   // Straps must stay valid on the first edge after release
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         test_mode_r <= scp_pkg::TM_NORMAL;
      end
      else if (!rstn_d_r)
      begin
         test_mode_r <= test_mode_nxt;
      end
   end

   // Keyboard-controller emulation
   logic write_out_armed_r;
   logic read_out_armed_r;
   logic addr_line20_gate_r;

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         write_out_armed_r <= 1'b0;
      end
      else if (wr_kbd_cmd)
      begin
         write_out_armed_r <= (io_wdata == scp_pkg::KBD_CMD_WRITE_OUT);
      end
      else if (wr_kbd_data)
      begin
         write_out_armed_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         addr_line20_gate_r <= 1'b0;
      end
      else if (wr_kbd_data && write_out_armed_r)
      begin
         addr_line20_gate_r <= io_wdata[scp_pkg::KBD_OUT_GATE_BIT];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         read_out_armed_r <= 1'b0;
      end
      else if (wr_kbd_cmd)
      begin
         read_out_armed_r <= (io_wdata == scp_pkg::KBD_CMD_READ_OUT);
      end
      else if (rd_kbd_data)
      begin
         read_out_armed_r <= 1'b0;
      end
   end

   // Warm reset: pending request waits for halt unless config allows direct
   logic reset_pending_r;
   logic warm_reset_r;
   logic [WR_CNT_W-1:0] warm_cnt_r;
   logic [7:0] cfg_r [scp_pkg::CFG_COUNT];
   logic fast_direct;

   assign fast_direct = cfg_r[scp_pkg::CFG_SYSCTL_IDX][scp_pkg::CFG_FAST_RESET_BIT];
   assign reset_request = (wr_kbd_cmd && io_wdata == scp_pkg::KBD_CMD_WARM_RESET
      && fast_direct) || (reset_pending_r && halt_cyc) || shutdown_cyc;

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         reset_pending_r <= 1'b0;
      end
      else if (wr_kbd_cmd && io_wdata == scp_pkg::KBD_CMD_WARM_RESET && !fast_direct)
      begin
         reset_pending_r <= 1'b1;
      end
      else if (halt_cyc)
      begin
         reset_pending_r <= 1'b0;
      end
   end

   // A request during a pulse restarts its width
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         warm_cnt_r <= '0;
         warm_reset_r <= 1'b0;
      end
      else if (reset_request)
      begin
         warm_cnt_r <= WR_CNT_W'(scp_pkg::WARM_RESET_CYCLES - 1);
         warm_reset_r <= 1'b1;
      end
      else if (warm_cnt_r != '0)
      begin
         warm_cnt_r <= warm_cnt_r - 1'b1;
      end
      else
      begin
         warm_reset_r <= 1'b0;
      end
   end

   // Indexed configuration space
   logic [7:0] index_r;
   logic index_valid_r;
   logic [7:0] cfg_sel;
   logic cfg_hit;

   assign cfg_sel = index_r - scp_pkg::CFG_FIRST_INDEX;
   assign cfg_hit = index_valid_r && (index_r >= scp_pkg::CFG_FIRST_INDEX)
      && (cfg_sel < 8'(scp_pkg::CFG_COUNT));

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         index_r <= 8'h00;
         index_valid_r <= 1'b0;
      end
      else if (wr_index)
      begin
         index_r <= io_wdata;
         index_valid_r <= 1'b1;
      end
      else if (wr_data || rd_data)
      begin
         index_valid_r <= 1'b0;
      end
   end

   genvar g;
   generate
      for (g = 0; g < scp_pkg::CFG_COUNT; g++)
      begin : g_cfg
         always_ff @(posedge sys_clk)
         begin
            if (!rstn)
            begin
               cfg_r[g] <= scp_pkg::CFG_RESET[g*8 +: 8];
            end
            else if (wr_data && cfg_hit && cfg_sel == 8'(g))
            begin
               // Masked bits keep reset value: reserved zero, revision fixed
               cfg_r[g] <= io_wdata & scp_pkg::CFG_WMASK[g*8 +: 8];
            end
         end
      end
   endgenerate

   logic [7:0] cfg_rd;

   always_comb
   begin
      cfg_rd = 8'h00;
      if (cfg_hit)
      begin
         cfg_rd = cfg_r[cfg_sel[3:0]];
         if (cfg_sel == 8'(scp_pkg::CFG_REV_IDX))
         begin
            cfg_rd[scp_pkg::CFG_REV_MSB:scp_pkg::CFG_REV_LSB] = scp_pkg::SILICON_REV;
         end
      end
   end

   // System port B
   logic [3:0] pb_ctrl_r;
   logic parity_flag_r;
   logic chanchk_flag_r;
   logic refresh_tog_r;
   logic parity_set;
   logic chanchk_set;

   assign parity_set = parity_error && !pb_ctrl_r[scp_pkg::PB_PARITY_DIS];
   assign chanchk_set = !channel_check_in_n && !pb_ctrl_r[scp_pkg::PB_CHANCHK_DIS];

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         pb_ctrl_r <= scp_pkg::PB_CTRL_RESET;
      end
      else if (wr_sys_b)
      begin
         pb_ctrl_r <= io_wdata[3:0];
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         parity_flag_r <= 1'b0;
      end
      else if (parity_set)
      begin
         parity_flag_r <= 1'b1;
      end
      else if (wr_sys_b && io_wdata[scp_pkg::PB_PARITY_DIS])
      begin
         parity_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         chanchk_flag_r <= 1'b0;
      end
      else if (chanchk_set)
      begin
         chanchk_flag_r <= 1'b1;
      end
      else if (wr_sys_b && io_wdata[scp_pkg::PB_CHANCHK_DIS])
      begin
         chanchk_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         refresh_tog_r <= 1'b0;
      end
      else if (refresh_pulse)
      begin
         refresh_tog_r <= !refresh_tog_r;
      end
   end

   // Read data path, one cycle after the strobe
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         io_rdata <= 8'h00;
         io_rdata_valid <= 1'b0;
      end
      else
      begin
         io_rdata_valid <= io_rd;
         if (rd_data)
         begin
            io_rdata <= cfg_rd;
         end
         else if (rd_kbd_data && read_out_armed_r)
         begin
            io_rdata <= {6'h00, addr_line20_gate_r, warm_reset_r};
         end
         else if (io_rd && io_addr == scp_pkg::PORT_SYS_B)
         begin
            io_rdata <= {parity_flag_r, chanchk_flag_r, timer_ch2_output,
               refresh_tog_r, pb_ctrl_r};
         end
         else
         begin
            io_rdata <= 8'h00;
         end
      end
   end

   // Functional pin levels, then test-mode override
   logic [scp_pkg::TEST_PINS-1:0] func_out;
   logic [scp_pkg::TEST_PINS-1:0] pin_out;
   logic [scp_pkg::TEST_PINS-1:0] pin_oe;

   assign func_out[0] = addr_line20_gate_r;
   assign func_out[1] = warm_reset_r;
   assign func_out[2] = timer_ch2_output && pb_ctrl_r[scp_pkg::PB_SPEAKER_EN];
   assign func_out[3] = pb_ctrl_r[scp_pkg::PB_TIMER_GATE];
   assign func_out[4] = (parity_flag_r && !pb_ctrl_r[scp_pkg::PB_PARITY_DIS])
      || (chanchk_flag_r && !pb_ctrl_r[scp_pkg::PB_CHANCHK_DIS]);

   scp_pin_test u_pin_test
   (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .test_mode(test_mode_r),
      .func_out(func_out),
      .pin_out(pin_out),
      .pin_oe(pin_oe)
   );

   assign addr20_gate_pin = pin_out[0];
   assign addr20_gate_pin_oe = pin_oe[0];
   assign processor_warm_reset = pin_out[1];
   assign processor_warm_reset_oe = pin_oe[1];
   assign speaker_out = pin_out[2];
   assign speaker_out_oe = pin_oe[2];
   assign timer_ch2_gate = pin_out[3];
   assign timer_ch2_gate_oe = pin_oe[3];
   assign nmi = pin_out[4];
   assign nmi_oe = pin_oe[4];
endmodule

// ---- hw/scp_pkg.sv ----
package scp_pkg;
   // Host I/O port numbers
   localparam logic [15:0] PORT_KBD_DATA = 16'h0060;
   localparam logic [15:0] PORT_SYS_B = 16'h0061;
   localparam logic [15:0] PORT_KBD_CMD = 16'h0064;
   localparam logic [15:0] PORT_CFG_INDEX = 16'h0022;
   localparam logic [15:0] PORT_CFG_DATA = 16'h0024;

   // Keyboard-controller command and data bytes
   localparam logic [7:0] KBD_CMD_WRITE_OUT = 8'hD1;
   localparam logic [7:0] KBD_CMD_READ_OUT = 8'hD0;
   localparam logic [7:0] KBD_CMD_WARM_RESET = 8'hFE;
   localparam int KBD_OUT_GATE_BIT = 1;
   localparam int KBD_OUT_RESET_BIT = 0;

   // Configuration space: 13 registers from index 20h upward
   localparam int CFG_COUNT = 13;
   localparam logic [7:0] CFG_FIRST_INDEX = 8'h20;
   localparam int CFG_REV_IDX = 0;
   localparam int CFG_SYSCTL_IDX = 1;
   localparam int CFG_REV_MSB = 7;
   localparam int CFG_REV_LSB = 6;
   localparam int CFG_FAST_RESET_BIT = 5;
   // Per-register reset values and writable-bit masks, entry 0 in the low byte
   localparam logic [CFG_COUNT*8-1:0] CFG_RESET = {80'h0, 8'hC0, 8'h40, 8'h00};
   localparam logic [CFG_COUNT*8-1:0] CFG_WMASK = {{11{8'hFF}}, 8'hF3, 8'h3F};
   // Revision value, arbitrary
   localparam logic [1:0] SILICON_REV = 2'h1;

   // System port B fields
   localparam int PB_PARITY_FLAG = 7;
   localparam int PB_CHANCHK_FLAG = 6;
   localparam int PB_TIMER_OUT = 5;
   localparam int PB_REFRESH_TOGGLE = 4;
   localparam int PB_CHANCHK_DIS = 3;
   localparam int PB_PARITY_DIS = 2;
   localparam int PB_SPEAKER_EN = 1;
   localparam int PB_TIMER_GATE = 0;
   localparam logic [3:0] PB_CTRL_RESET = 4'h0;

   // Warm reset pulse width
   localparam int CLK_MHZ = 50;
   localparam int WARM_RESET_NS = 1000;
   localparam int WARM_RESET_CYCLES = (WARM_RESET_NS * CLK_MHZ) / 1000;

   // Number of pins under test-mode control
   localparam int TEST_PINS = 5;

   typedef enum logic [1:0] {
      TM_NORMAL,
      TM_TRISTATE,
      TM_ODD_HIGH,
      TM_EVEN_HIGH
   } scp_test_type;
endpackage

// ---- hw/scp_pin_test.sv ----
`timescale 1ns/100ps
module scp_pin_test
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire scp_pkg::scp_test_type test_mode,
   input wire logic [scp_pkg::TEST_PINS-1:0] func_out,
   output logic [scp_pkg::TEST_PINS-1:0] pin_out,
   output logic [scp_pkg::TEST_PINS-1:0] pin_oe
);
   // Pin k is numbered k+1, so even k is an odd-numbered pin
   genvar k;
   generate
      for (k = 0; k < scp_pkg::TEST_PINS; k++)
      begin : g_pin
         always_ff @(posedge sys_clk)
         begin
            if (!rstn)
            begin
               pin_out[k] <= 1'b0;
               pin_oe[k] <= 1'b1;
            end
            else
            begin
               case (test_mode)
                  scp_pkg::TM_TRISTATE:
                  begin
                     pin_out[k] <= 1'b0;
                     pin_oe[k] <= 1'b0;
                  end
                  scp_pkg::TM_ODD_HIGH:
                  begin
                     pin_out[k] <= (k % 2 == 0);
                     pin_oe[k] <= 1'b1;
                  end
                  scp_pkg::TM_EVEN_HIGH:
                  begin
                     pin_out[k] <= (k % 2 != 0);
                     pin_oe[k] <= 1'b1;
                  end
                  default:
                  begin
                     pin_out[k] <= func_out[k];
                     pin_oe[k] <= 1'b1;
                  end
               endcase
            end
         end
      end
   endgenerate
endmodule

// ---- verification/scp_timer_model.sv ----
`timescale 1ns/100ps
module scp_timer_model
(
   input wire logic sys_clk,
   input wire logic timer_ch2_gate,
   output logic timer_ch2_output
);
   logic [3:0] div_r = 4'h0;
   assign timer_ch2_output = div_r[3];
   // Counts only while gated, so the tone level freezes when the gate drops
   always @(posedge sys_clk)
   begin
      if (timer_ch2_gate === 1'b1)
         div_r <= div_r + 4'h1;
   end
endmodule

// ---- verification/scp_properties.sv ----
`timescale 1ns/100ps
module scp_properties
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [15:0] io_addr,
   input wire logic [7:0] io_wdata,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic io_rdata_valid,
   input wire logic cyc_strobe,
   input wire logic mem_or_io_select,
   input wire logic data_or_control_select,
   input wire logic cyc_write,
   input wire logic [2:0] strap_in,
   input wire logic timer_ch2_output,
   input wire logic addr20_gate_pin,
   input wire logic addr20_gate_pin_oe,
   input wire logic processor_warm_reset,
   input wire logic speaker_out,
   input wire logic nmi_oe
);
   logic seen_r;
   logic live_r;
   logic [2:0] mode_r;
   logic [7:0] hi_cnt_r;
   logic norm;
   logic float_m;
   logic spec_cyc;
   logic fe_wr;
   logic kbd_wr;
   assign norm = live_r && mode_r == 3'h3;
   assign float_m = live_r && mode_r == 3'h1;
   assign spec_cyc = cyc_strobe && !mem_or_io_select && !data_or_control_select && cyc_write;
   assign fe_wr = io_wr && io_addr == scp_pkg::PORT_KBD_CMD
      && io_wdata == scp_pkg::KBD_CMD_WARM_RESET;
   assign kbd_wr = io_wr && io_addr == scp_pkg::PORT_KBD_DATA;
   logic cause;
   assign cause = fe_wr || spec_cyc;
   // Pins follow the captured straps one edge after capture
   always_ff @(posedge sys_clk)
   begin
      if (!rstn)
      begin
         seen_r <= 1'b0;
         live_r <= 1'b0;
      end
      else
      begin
         seen_r <= 1'b1;
         live_r <= seen_r;
         if (!seen_r)
            mode_r <= strap_in;
      end
   end
   always_ff @(posedge sys_clk)
   begin
      if (!rstn || !processor_warm_reset)
         hi_cnt_r <= 8'h00;
      else
         hi_cnt_r <= hi_cnt_r + 8'h01;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   chk_read_answer_next: assert property (io_rd |=> io_rdata_valid)
      else $error("read answer missing");
   chk_answer_has_read: assert property (io_rdata_valid |-> $past(io_rd))
      else $error("read answer without read");
   chk_speaker_needs_tone: assert property (norm && speaker_out
      |-> $past(timer_ch2_output))
      else $error("speaker high without tone");
   chk_warm_pulse_width: assert property (norm && $fell(processor_warm_reset)
      |-> hi_cnt_r == 8'h32)
      else $error("warm reset width wrong");
   chk_tristate_floats: assert property (float_m |-> !addr20_gate_pin_oe && !nmi_oe)
      else $error("pin driven in float mode");
   chk_normal_drives: assert property (norm |-> addr20_gate_pin_oe && nmi_oe)
      else $error("pin not driven in normal mode");
   chk_warm_has_cause: assert property (norm && $rose(processor_warm_reset)
      |-> $past(cause, 2))
      else $error("warm reset without cause");
   chk_gate_latched: assert property (norm && $changed(addr20_gate_pin)
      |-> $past(kbd_wr, 2))
      else $error("gate moved without data write");
   cov_warm: cover property (norm && $rose(processor_warm_reset));
   cov_gate: cover property (norm && $rose(addr20_gate_pin));
   cov_float: cover property (float_m);
endmodule

bind scp_top scp_properties chk (.*);

// ---- verification/testbench.sv ----
`timescale 1ns/100ps
module testbench;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [15:0] io_addr = 16'h0000;
   logic [7:0] io_wdata = 8'h00;
   logic io_wr = 1'b0;
   logic io_rd = 1'b0;
   logic [7:0] io_rdata;
   logic io_rdata_valid;
   logic cyc_strobe = 1'b0;
   logic mem_or_io_select = 1'b0;
   logic data_or_control_select = 1'b0;
   logic cyc_write = 1'b1;
   logic cyc_halt_sel = 1'b0;
   logic [2:0] strap_in = 3'h3;
   logic timer_ch2_output;
   logic refresh_pulse = 1'b0;
   logic parity_error = 1'b0;
   logic channel_check_in_n = 1'b1;
   logic addr20_gate_pin, processor_warm_reset, speaker_out, timer_ch2_gate, nmi;
   logic addr20_gate_pin_oe, processor_warm_reset_oe, speaker_out_oe, timer_ch2_gate_oe, nmi_oe;
   wire logic [4:0] pins = {nmi, timer_ch2_gate, speaker_out, processor_warm_reset,
      addr20_gate_pin};
   wire logic [4:0] oes = {nmi_oe, timer_ch2_gate_oe, speaker_out_oe, processor_warm_reset_oe,
      addr20_gate_pin_oe};
   logic tog = 1'b0;
   logic [2:0] codes [3] = '{3'h1, 3'h0, 3'h2};
   logic [7:0] pexp [3] = '{8'h00, 8'h15, 8'h0A};
   int n_fail = 0;
   int total_checks = 0;
   always #10 sys_clk = !sys_clk;
   scp_top dut (.*);
   scp_timer_model timer_model (.*);
   task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic settle();
      repeat (3) @(posedge sys_clk);
      #1;
   endtask
   task automatic reset_dut(input logic [2:0] s);
      @(posedge sys_clk);
      rstn <= 1'b0;
      strap_in <= s;
      repeat (8) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (2) @(posedge sys_clk);
   endtask
   task automatic io_write(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      io_wr <= 1'b1;
      io_addr <= a;
      io_wdata <= d;
      @(posedge sys_clk);
      io_wr <= 1'b0;
   endtask
   task automatic io_read(input logic [15:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      io_rd <= 1'b1;
      io_addr <= a;
      @(posedge sys_clk);
      io_rd <= 1'b0;
      #1;
      check_val({7'h0, io_rdata_valid}, 8'h01);
      check_val(io_rdata, exp);
   endtask
   // Index is consumed by every data access, so each access rewrites it
   task automatic cfg_wr(input logic [7:0] i, input logic [7:0] d);
      io_write(16'h0022, i);
      io_write(16'h0024, d);
   endtask
   task automatic cfg_rd(input logic [7:0] i, input logic [7:0] exp);
      io_write(16'h0022, i);
      io_read(16'h0024, exp);
   endtask
   // Memory-space cycle with the same halt code must not count as special
   task automatic special(input logic halt, input logic mio);
      @(posedge sys_clk);
      cyc_strobe <= 1'b1;
      cyc_halt_sel <= halt;
      mem_or_io_select <= mio;
      @(posedge sys_clk);
      cyc_strobe <= 1'b0;
      mem_or_io_select <= 1'b0;
   endtask
   task automatic warm_pulse(input logic [7:0] exp_w);
      logic [7:0] w;
      w = 8'h00;
      repeat (8)
      begin
         @(posedge sys_clk);
         #1;
         if (processor_warm_reset === 1'b1)
            break;
      end
      while (processor_warm_reset === 1'b1 && w < 8'hC8)
      begin
         w++;
         @(posedge sys_clk);
         #1;
      end
      check_val(w, exp_w);
   endtask
   // Source 0 parity, 1 channel check, 2 refresh
   task automatic src_pulse(input int s);
      @(posedge sys_clk);
      parity_error <= (s == 0);
      channel_check_in_n <= (s != 1);
      refresh_pulse <= (s == 2);
      @(posedge sys_clk);
      parity_error <= 1'b0;
      channel_check_in_n <= 1'b1;
      refresh_pulse <= 1'b0;
      settle();
   endtask
   function automatic logic [7:0] pb(input logic [1:0] f, input logic [3:0] c);
      return {f, timer_ch2_output, tog, c};
   endfunction
   initial
   begin
      #200000;
      n_fail++;
      complete_run();
   end
   initial
   begin
      reset_dut(3'h3);
      check_val({3'h0, oes}, 8'h1F);
      io_read(16'h0061, pb(2'h0, 4'h0));
      cfg_rd(8'h20, {scp_pkg::SILICON_REV, 6'h00});
      cfg_wr(8'h20, 8'hFF);
      cfg_rd(8'h20, {scp_pkg::SILICON_REV, 6'h3F});
      io_read(16'h0024, 8'h00);
      cfg_rd(8'h21, 8'h40);
      cfg_wr(8'h21, 8'hFF);
      cfg_rd(8'h21, 8'hF3);
      cfg_rd(8'h2C, 8'h00);
      cfg_rd(8'h2D, 8'h00);
      io_read(16'h0030, 8'h00);
      io_write(16'h0064, 8'hD1);
      io_write(16'h0060, 8'h02);
      io_write(16'h0064, 8'hD0);
      io_read(16'h0060, 8'h02);
      io_write(16'h0064, 8'hD1);
      io_write(16'h0064, 8'hD0);
      io_write(16'h0060, 8'h00);
      settle();
      check_val({7'h0, addr20_gate_pin}, 8'h01);
      io_write(16'h0064, 8'hD1);
      io_write(16'h0060, 8'h00);
      settle();
      check_val({7'h0, addr20_gate_pin}, 8'h00);
      io_write(16'h0064, 8'hD1);
      io_write(16'h0060, 8'h02);
      io_write(16'h0064, 8'hFE);
      warm_pulse(8'h32);
      io_write(16'h0064, 8'hFE);
      io_write(16'h0064, 8'hD0);
      io_read(16'h0060, 8'h03);
      repeat (60) @(posedge sys_clk);
      cfg_wr(8'h21, 8'h40);
      io_write(16'h0064, 8'hFE);
      warm_pulse(8'h00);
      special(1'b1, 1'b1);
      warm_pulse(8'h00);
      special(1'b1, 1'b0);
      warm_pulse(8'h32);
      special(1'b0, 1'b0);
      warm_pulse(8'h32);
      io_write(16'h0061, 8'h03);
      settle();
      check_val({7'h0, timer_ch2_gate}, 8'h01);
      for (int k = 0; k < 40 && timer_ch2_output !== 1'b1; k++)
         @(posedge sys_clk);
      io_write(16'h0061, 8'h02);
      settle();
      check_val({7'h0, speaker_out}, 8'h01);
      io_read(16'h0061, pb(2'h0, 4'h2));
      io_write(16'h0061, 8'h00);
      settle();
      check_val({7'h0, speaker_out}, 8'h00);
      for (int k = 0; k < 3; k++)
      begin
         src_pulse(2);
         tog = !tog;
         io_read(16'h0061, pb(2'h0, 4'h0));
      end
      for (int s = 0; s < 2; s++)
      begin
         src_pulse(s);
         io_read(16'h0061, pb(s ? 2'h1 : 2'h2, 4'h0));
         check_val({7'h0, nmi}, 8'h01);
         io_write(16'h0061, s ? 8'h08 : 8'h04);
         settle();
         io_read(16'h0061, pb(2'h0, s ? 4'h8 : 4'h4));
         check_val({7'h0, nmi}, 8'h00);
         src_pulse(s);
         io_read(16'h0061, pb(2'h0, s ? 4'h8 : 4'h4));
         check_val({7'h0, nmi}, 8'h00);
         io_write(16'h0061, 8'h00);
      end
      for (int m = 0; m < 3; m++)
      begin
         reset_dut(codes[m]);
         settle();
         check_val({3'h0, pins}, pexp[m]);
         check_val({3'h0, oes}, (m == 0) ? 8'h00 : 8'h1F);
      end
      complete_run();
   end
endmodule
